// [src/reload_down_counter_timer.sv]
// Purpose: One 16-bit presettable down-counting timer channel with reload and underflow flag.
// Assumes: Oscillator, event and debug inputs are asynchronous levels from outside ref_clk.
// Notes:   The counter clock is a tick enable built from source edges; ref_clk is the only clock.
// Function
// - One mode bit: 1 one-shot, 0 repeat.
// - Repeat mode reloads on every underflow.
// - One-shot reloads, halts, clears run status.
// - Period lasts reload value plus one ticks.
// - Underflow pulse sets flag, feeds peripherals.
// - Run bit starts or stops, reads status.
// - Preset copies reload, reads pending, self-clears.
// - Enable bit gates the counter clock.
// - Reload resets to ones, used twice.
// - Live counter readable, resets to ones.
// - Flag sets on underflow, write one clears.
// - Interrupt only with flag and enable set.
// - Two-bit field picks the clock source.
// - Divider code sets ratio per source.
// - Debug-run bit keeps clock in debug halt.
// - Code three uses external clock input.
// - Event channel counts event input rising edges.
// - Debug halt freezes channel, then resumes.
`timescale 1ns/1ps

module reload_down_counter_timer
   import reload_timer_pkg::*;
(
   input  wire logic              ref_clk,
   input  wire logic              rstn,
   input  wire bus_req_s          bus,
   output logic [DATA_W-1:0]      rdata,
   input  wire logic              internal_osc,
   input  wire logic              low_speed_osc,
   input  wire logic              high_speed_osc,
   input  wire logic              external_clock_input,
   input  wire logic              event_input,
   input  wire logic              debug_halt,
   output logic                   irq,
   output logic                   underflow_pulse
);

   // Synchroniser for all asynchronous inputs.
   logic [IN_COUNT-1:0] raw_in;
   logic [IN_COUNT-1:0] sync_a;
   logic [IN_COUNT-1:0] sync_b;

   assign raw_in = {debug_halt, event_input, external_clock_input,
                    high_speed_osc, low_speed_osc, internal_osc};

   genvar gi;
   generate
      for (gi = 0; gi < IN_COUNT; gi++) begin : g_sync
         always_ff @(posedge ref_clk or negedge rstn) begin
            if (!rstn) begin
               sync_a[gi] <= 1'b0;
               sync_b[gi] <= 1'b0;
            end else begin
               sync_a[gi] <= raw_in[gi];
               sync_b[gi] <= sync_a[gi];
            end
         end
      end
   endgenerate

   // Channel state.
   typedef struct packed {
      logic               debug_run;
      logic [3:0]         clock_divider;
      clock_source_e      clock_source_select;
      logic               oneshot_select;
      logic               channel_enable;
      logic [DATA_W-1:0]  reload_value;
      logic [DATA_W-1:0]  counter_value;
      logic               underflow_flag;
      logic               underflow_irq_enable;
      run_state_e         run_state;
      logic               start_pend;
      logic               stop_pend;
      logic               preset_pend;
      logic [PRESC_W-1:0] presc;
      logic               src_prev;
      logic               uf_pulse;
      logic [DATA_W-1:0]  rdata;
   } chan_s;

   chan_s st;
   chan_s next_st;

   logic               src_level;
   logic               src_edge;
   logic [3:0]         eff_div;
   logic [PRESC_W-1:0] div_mask;
   logic               gate_open;
   logic               tick;
   logic               uf_now;
   logic               wr_ctl;
   logic               enable_after;

   // Source selection and divider ratio.
   always_comb begin
      unique case (st.clock_source_select)
         SRC_INTERNAL: begin
            src_level = sync_b[IN_INTERNAL];
            eff_div   = st.clock_divider;
         end
         SRC_LOW: begin
            src_level = sync_b[IN_LOW];
            eff_div   = (st.clock_divider <= LOW_SPEED_MAX_DIV) ? st.clock_divider : 4'h0;
         end
         SRC_HIGH: begin
            src_level = sync_b[IN_HIGH];
            eff_div   = st.clock_divider;
         end
         SRC_EXTERNAL: begin
            // Event channels count rising edges of the event input.
            src_level = HAS_EVENT_COUNTER ? sync_b[IN_EVENT] : sync_b[IN_EXTERNAL];
            eff_div   = 4'h0;
         end
      endcase
   end

   assign div_mask  = PRESC_W'((16'h0001 << eff_div) - 16'h0001);
   assign src_edge  = src_level & ~st.src_prev;
   // Gating stops the prescaler too, so the divider phase is kept across a halt.
   assign gate_open = st.channel_enable & ~(sync_b[IN_DEBUG] & ~st.debug_run);
   assign tick      = gate_open & src_edge & ((st.presc & div_mask) == div_mask);
   assign uf_now    = tick & ~st.preset_pend & (st.run_state == RUN_COUNTING)
                      & (st.counter_value == 16'h0000);
   assign wr_ctl    = bus.wr & (bus.addr == OFS_RUN_CONTROL);
   assign enable_after = bus.wdata[CHANNEL_ENABLE_BIT];

   always_comb begin
      next_st          = st;
      next_st.src_prev = src_level;
      next_st.uf_pulse = uf_now;

      if (gate_open && src_edge) begin
         next_st.presc = ((st.presc & div_mask) == div_mask) ? '0 : st.presc + 15'h0001;
      end

      // Counter clock step: a pending preset replaces counting; start and stop are applied after counting.
      if (tick) begin
         if (st.preset_pend) begin
            next_st.counter_value = st.reload_value;
            next_st.preset_pend   = 1'b0;
         end else if (st.run_state == RUN_COUNTING) begin
            if (st.counter_value == 16'h0000) begin
               next_st.counter_value = st.reload_value;
               if (st.oneshot_select) begin
                  next_st.run_state = RUN_IDLE;
               end
            end else begin
               next_st.counter_value = st.counter_value - 16'h0001;
            end
         end
         if (st.start_pend) begin
            next_st.run_state  = RUN_COUNTING;
            next_st.start_pend = 1'b0;
         end else if (st.stop_pend) begin
            next_st.run_state = RUN_IDLE;
            next_st.stop_pend = 1'b0;
         end
      end

      // A clear in the cycle of an underflow loses to the set.
      next_st.underflow_flag = (st.underflow_flag & ~(bus.wr && bus.addr == OFS_INTERRUPT_FLAG
                               && bus.wdata[UNDERFLOW_BIT])) | uf_now;

      if (bus.wr) begin
         unique case (bus.addr)
            OFS_CLOCK_SELECT_CONTROL: begin
               next_st.debug_run           = bus.wdata[DEBUG_RUN_BIT];
               next_st.clock_divider       = bus.wdata[CLOCK_DIVIDER_LSB +: 4];
               next_st.clock_source_select = clock_source_e'(bus.wdata[CLOCK_SOURCE_LSB +: 2]);
            end
            OFS_MODE_SELECT: begin
               next_st.oneshot_select = bus.wdata[ONESHOT_BIT];
            end
            OFS_RUN_CONTROL: begin
               next_st.channel_enable = enable_after;
            end
            OFS_RELOAD_VALUE: begin
               next_st.reload_value = bus.wdata;
            end
            OFS_INTERRUPT_ENABLE: begin
               next_st.underflow_irq_enable = bus.wdata[UNDERFLOW_BIT];
            end
            default: begin
            end
         endcase
      end

      // Start and preset requests are only accepted with the enable bit set in the same write; stops always.
      if (wr_ctl) begin
         if (bus.wdata[RUN_BIT] && enable_after) begin
            next_st.start_pend = 1'b1;
            next_st.stop_pend  = 1'b0;
         end else if (!bus.wdata[RUN_BIT]) begin
            next_st.stop_pend  = (st.run_state == RUN_COUNTING) || st.start_pend;
            next_st.start_pend = 1'b0;
         end
         if (bus.wdata[PRESET_BIT] && enable_after) begin
            next_st.preset_pend = 1'b1;
         end
      end

      next_st.rdata = '0;
      if (bus.rd) begin
         unique case (bus.addr)
            OFS_CLOCK_SELECT_CONTROL: begin
               next_st.rdata[DEBUG_RUN_BIT]              = st.debug_run;
               next_st.rdata[CLOCK_DIVIDER_LSB +: 4]     = st.clock_divider;
               next_st.rdata[CLOCK_SOURCE_LSB +: 2]      = st.clock_source_select;
            end
            OFS_MODE_SELECT: begin
               next_st.rdata[ONESHOT_BIT] = st.oneshot_select;
            end
            OFS_RUN_CONTROL: begin
               // A pending start reads as running; a stop pending on a counting channel reads running until done.
               next_st.rdata[RUN_BIT]            = (st.run_state == RUN_COUNTING)
                                                   | st.start_pend;
               next_st.rdata[PRESET_BIT]         = st.preset_pend;
               next_st.rdata[CHANNEL_ENABLE_BIT] = st.channel_enable;
            end
            OFS_RELOAD_VALUE: begin
               next_st.rdata = st.reload_value;
            end
            OFS_COUNTER_VALUE: begin
               next_st.rdata = st.counter_value;
            end
            OFS_INTERRUPT_FLAG: begin
               next_st.rdata[UNDERFLOW_BIT] = st.underflow_flag;
            end
            OFS_INTERRUPT_ENABLE: begin
               next_st.rdata[UNDERFLOW_BIT] = st.underflow_irq_enable;
            end
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         st.debug_run            <= 1'b0;
         st.clock_divider        <= DIVIDER_RESET;
         st.clock_source_select  <= SRC_INTERNAL;
         st.oneshot_select       <= 1'b0;
         st.channel_enable       <= 1'b0;
         st.reload_value         <= RELOAD_RESET;
         st.counter_value        <= COUNTER_RESET;
         st.underflow_flag       <= 1'b0;
         st.underflow_irq_enable <= 1'b0;
         st.run_state            <= RUN_IDLE;
         st.start_pend           <= 1'b0;
         st.stop_pend            <= 1'b0;
         st.preset_pend          <= 1'b0;
         st.presc                <= '0;
         st.src_prev             <= 1'b0;
         st.uf_pulse             <= 1'b0;
         st.rdata                <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign rdata           = st.rdata;
   assign underflow_pulse = st.uf_pulse;
   assign irq             = st.underflow_flag & st.underflow_irq_enable;

   // Checks on the channel behaviour.
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rstn);

   sequence start_write_s;
      wr_ctl && bus.wdata[RUN_BIT] && bus.wdata[CHANNEL_ENABLE_BIT];
   endsequence

   sequence counter_read_s;
      bus.rd && bus.addr == OFS_COUNTER_VALUE;
   endsequence

   flag_on_underflow_a: assert property (underflow_pulse |-> st.underflow_flag)
      else $error("underflow did not set the flag");

   underflow_reload_a: assert property (uf_now |=> st.counter_value == $past(st.reload_value))
      else $error("counter not reloaded on underflow");

   oneshot_halt_a: assert property (uf_now && st.oneshot_select && !st.start_pend
                                    |=> st.run_state == RUN_IDLE)
      else $error("one-shot did not halt after underflow");

   repeat_continue_a: assert property (uf_now && !st.oneshot_select && !st.stop_pend
                                       |=> st.run_state == RUN_COUNTING)
      else $error("repeat mode stopped at underflow");

   count_step_a: assert property (tick && st.run_state == RUN_COUNTING && !st.preset_pend
                                  && st.counter_value != 16'h0000
                                  |=> st.counter_value == $past(st.counter_value) - 16'h0001)
      else $error("counter did not decrement by one");

   preset_done_a: assert property ($fell(st.preset_pend) |-> st.counter_value == st.reload_value)
      else $error("preset did not load reload value");

   start_pending_a: assert property (start_write_s |=> st.start_pend
                                     || st.run_state == RUN_COUNTING)
      else $error("start request lost");

   gate_freeze_a: assert property (!gate_open |=> $stable(st.counter_value))
      else $error("counter moved while clock gated");

   irq_gate_a: assert property (!st.underflow_irq_enable |-> !irq)
      else $error("interrupt raised while disabled");

   flag_clear_a: assert property (bus.wr && bus.addr == OFS_INTERRUPT_FLAG
                                  && bus.wdata[UNDERFLOW_BIT] && !uf_now
                                  |=> !st.underflow_flag)
      else $error("write one did not clear the flag");

   counter_read_a: assert property (counter_read_s |=> rdata == $past(st.counter_value))
      else $error("counter read returned wrong data");

   external_undivided_a: assert property (st.clock_source_select == SRC_EXTERNAL
                                          && gate_open && src_edge |-> tick)
      else $error("external source was divided");

   sequence underflow_s;
      uf_now;
   endsequence

   sequence pulse_out_s;
      underflow_pulse ##1 !underflow_pulse;
   endsequence

   // The pulse is registered, so it trails the counter clock step by one cycle.
   pulse_follows_a: assert property (underflow_s |=> pulse_out_s)
      else $error("underflow pulse missing or too long");

   pulse_cause_a: assert property (underflow_pulse |-> $past(uf_now))
      else $error("underflow pulse without underflow");

   preset_load_a: assert property (tick && st.preset_pend
                                   |=> st.counter_value == $past(st.reload_value))
      else $error("preset did not copy the reload value");

   start_apply_a: assert property (tick && st.start_pend
                                   |=> st.run_state == RUN_COUNTING)
      else $error("pending start not applied at tick");

   stop_apply_a: assert property (tick && st.stop_pend && !st.start_pend
                                  |=> st.run_state == RUN_IDLE)
      else $error("pending stop not applied at tick");

   flag_hold_a: assert property (st.underflow_flag
                                 && !(bus.wr && bus.addr == OFS_INTERRUPT_FLAG)
                                 |=> st.underflow_flag)
      else $error("flag cleared without a write of one");

   // A refused request must not leave anything pending behind.
   enable_refused_a: assert property (wr_ctl && !bus.wdata[CHANNEL_ENABLE_BIT]
                                      && !st.start_pend && !st.preset_pend
                                      |=> !st.start_pend && !st.preset_pend)
      else $error("request taken without channel enable");

   debug_freeze_a: assert property (sync_b[IN_DEBUG] && !st.debug_run
                                    |=> $stable(st.counter_value) && $stable(st.run_state))
      else $error("channel moved during debug halt");

   rdata_idle_a: assert property (!bus.rd |=> rdata == '0)
      else $error("read data not zero outside a read");

endmodule

// [src/reload_timer_pkg.sv]
// Purpose: Shared constants and types for the reload down-counter timer channel.
// Assumes: Registers are 16 bits wide and sit at even byte offsets on a small plain port.
// Notes:   Offsets, field positions and reset values are collected here, once each.
package reload_timer_pkg;

   localparam int ADDR_W = 4;
   localparam int DATA_W = 16;
   localparam int PRESC_W = 15;

   // Register offsets.
   localparam logic [ADDR_W-1:0] OFS_CLOCK_SELECT_CONTROL = 4'h0;
   localparam logic [ADDR_W-1:0] OFS_MODE_SELECT          = 4'h2;
   localparam logic [ADDR_W-1:0] OFS_RUN_CONTROL          = 4'h4;
   localparam logic [ADDR_W-1:0] OFS_RELOAD_VALUE         = 4'h6;
   localparam logic [ADDR_W-1:0] OFS_COUNTER_VALUE        = 4'h8;
   localparam logic [ADDR_W-1:0] OFS_INTERRUPT_FLAG       = 4'hA;
   localparam logic [ADDR_W-1:0] OFS_INTERRUPT_ENABLE     = 4'hC;

   // Field positions.
   localparam int DEBUG_RUN_BIT      = 8;
   localparam int CLOCK_DIVIDER_LSB  = 4;
   localparam int CLOCK_SOURCE_LSB   = 0;
   localparam int ONESHOT_BIT        = 0;
   localparam int RUN_BIT            = 8;
   localparam int PRESET_BIT         = 1;
   localparam int CHANNEL_ENABLE_BIT = 0;
   localparam int UNDERFLOW_BIT      = 0;

   // Values after reset.
   localparam logic [DATA_W-1:0] RELOAD_RESET  = 16'hFFFF;
   localparam logic [DATA_W-1:0] COUNTER_RESET = 16'hFFFF;
   localparam logic [3:0]        DIVIDER_RESET = 4'h0;

   // Highest divider code that still divides on the low-speed source.
   localparam logic [3:0] LOW_SPEED_MAX_DIV = 4'h8;

   // This channel has no event counter, so code 3 takes the external clock input.
   localparam logic HAS_EVENT_COUNTER = 1'b0;

   // Bit order of the synchronised clock and debug inputs.
   localparam int IN_INTERNAL = 0;
   localparam int IN_LOW      = 1;
   localparam int IN_HIGH     = 2;
   localparam int IN_EXTERNAL = 3;
   localparam int IN_EVENT    = 4;
   localparam int IN_DEBUG    = 5;
   localparam int IN_COUNT    = 6;

   typedef enum logic [1:0] {
      SRC_INTERNAL = 2'h0,
      SRC_LOW      = 2'h1,
      SRC_HIGH     = 2'h2,
      SRC_EXTERNAL = 2'h3
   } clock_source_e;

   typedef enum logic {
      RUN_IDLE    = 1'b0,
      RUN_COUNTING = 1'b1
   } run_state_e;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic              wr;
      logic              rd;
   } bus_req_s;

endpackage

// [sim/source_model.sv]
// Purpose: Far-side model: oscillator and event sources, and an observer of underflow pulses.
// Assumes: Start offsets keep every source edge away from ref_clk edges.
// Notes:   pulse_gap is the ref_clk count between the last two underflow pulses.
`timescale 1ns/1ps

module source_model
   import reload_timer_pkg::*;
(
   input  wire logic ref_clk,
   input  wire logic rstn,
   input  wire logic underflow_pulse,
   output logic      internal_osc,
   output logic      low_speed_osc,
   output logic      high_speed_osc,
   output logic      external_clock_input,
   output logic      event_input,
   output int        pulse_count,
   output int        pulse_gap
);
   // Half periods in ns: 8, 12, 6, 10 and 7 ref_clk periods in full.
   localparam int HALF [5] = '{400, 600, 300, 500, 350};
   logic [4:0] src;
   int         since;

   for (genvar i = 0; i < 5; i++) begin : g_src
      initial begin
         src[i] = 1'b0;
         #(37 + 11 * i);
         forever #(HALF[i]) src[i] = ~src[i];
      end
   end
   assign internal_osc         = src[IN_INTERNAL];
   assign low_speed_osc        = src[IN_LOW];
   assign high_speed_osc       = src[IN_HIGH];
   assign external_clock_input = src[IN_EXTERNAL];
   assign event_input          = src[IN_EVENT];

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         since       <= 0;
         pulse_gap   <= 0;
         pulse_count <= 0;
      end else if (underflow_pulse) begin
         pulse_gap   <= since;
         since       <= 1;
         pulse_count <= pulse_count + 1;
      end else begin
         since <= since + 1;
      end
   end
endmodule

// [sim/test_reload_down_counter_timer.sv]
// Purpose: Self-checking bench for the reload down-counter timer channel.
// Assumes: Source periods of the far-side model are 8, 12, 6 and 10 ref_clk cycles.
// Notes:   Underflow periods are measured by the model in whole ref_clk cycles.
`timescale 1ns/1ps

`define CHK(nm, exp, got) begin checks++; if ((got) !== (exp)) begin n_mismatch++; \
   $display("[ERR] %s exp %0h got %0h", nm, exp, got); end end

module test_reload_down_counter_timer
   import reload_timer_pkg::*;
;
   localparam logic [ADDR_W-1:0] RA [8] = '{OFS_CLOCK_SELECT_CONTROL, OFS_MODE_SELECT,
      OFS_RUN_CONTROL, OFS_RELOAD_VALUE, OFS_COUNTER_VALUE, OFS_INTERRUPT_FLAG,
      OFS_INTERRUPT_ENABLE, 4'hE};
   localparam logic [DATA_W-1:0] RV [8] = '{16'h0000, 16'h0000, 16'h0000, 16'hFFFF,
      16'hFFFF, 16'h0000, 16'h0000, 16'h0000};
   localparam logic [DATA_W-1:0] CK [6] = '{16'h0000, 16'h0010, 16'h00F1, 16'h0021,
      16'h0002, 16'h0053};
   localparam int GAP [6] = '{24, 48, 36, 144, 18, 30};

   bus_req_s          bus;
   logic [DATA_W-1:0] rdata;
   logic [DATA_W-1:0] v;
   logic [DATA_W-1:0] a;
   logic              ref_clk;
   logic              rstn;
   logic              debug_halt;
   logic              irq;
   logic              underflow_pulse;
   logic              internal_osc;
   logic              low_speed_osc;
   logic              high_speed_osc;
   logic              external_clock_input;
   logic              event_input;
   int                pulse_count;
   int                pulse_gap;
   int                n_mismatch;
   int                checks;
   int                n0;

   reload_down_counter_timer DUT (
      .ref_clk(ref_clk), .rstn(rstn), .bus(bus), .rdata(rdata),
      .internal_osc(internal_osc), .low_speed_osc(low_speed_osc),
      .high_speed_osc(high_speed_osc), .external_clock_input(external_clock_input),
      .event_input(event_input), .debug_halt(debug_halt), .irq(irq),
      .underflow_pulse(underflow_pulse)
   );

   source_model far (
      .ref_clk(ref_clk), .rstn(rstn), .underflow_pulse(underflow_pulse),
      .internal_osc(internal_osc), .low_speed_osc(low_speed_osc),
      .high_speed_osc(high_speed_osc), .external_clock_input(external_clock_input),
      .event_input(event_input), .pulse_count(pulse_count), .pulse_gap(pulse_gap)
   );

   task automatic wr(input logic [ADDR_W-1:0] ad, input logic [DATA_W-1:0] d);
      @(posedge ref_clk);
      bus.addr  <= ad;
      bus.wdata <= d;
      bus.wr    <= 1'b1;
      @(posedge ref_clk);
      bus.wr <= 1'b0;
   endtask

   task automatic rd(input logic [ADDR_W-1:0] ad, output logic [DATA_W-1:0] d);
      @(posedge ref_clk);
      bus.addr <= ad;
      bus.rd   <= 1'b1;
      @(posedge ref_clk);
      bus.rd <= 1'b0;
      @(posedge ref_clk);
      d = rdata;
   endtask

   task automatic rd_chk(input logic [ADDR_W-1:0] ad, input logic [DATA_W-1:0] e,
                         input string nm);
      logic [DATA_W-1:0] d;
      rd(ad, d);
      `CHK(nm, e, d)
   endtask

   // Polls run_control; a bound that runs out is reported like a mismatch.
   task automatic wait_ctl(input logic [DATA_W-1:0] mask, input logic [DATA_W-1:0] val);
      int i;
      for (i = 0; i < 2000; i++) begin
         rd(OFS_RUN_CONTROL, v);
         if ((v & mask) === val) break;
      end
      `CHK("run_control wait", val, v & mask)
   endtask

   task automatic wait_pulses(input int n);
      int base;
      base = pulse_count;
      for (int i = 0; i < 20000 && pulse_count < base + n; i++) @(posedge ref_clk);
      `CHK("underflow count", base + n, pulse_count)
   endtask

   task automatic test_done;
      if (n_mismatch == 0 && checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask

   initial begin
      ref_clk = 1'b0;
      forever #50 ref_clk = ~ref_clk;
   end

   initial begin
      repeat (90000) @(posedge ref_clk);
      n_mismatch++;
      test_done();
   end

   initial begin
      bus        = '0;
      rstn       = 1'b0;
      debug_halt = 1'b0;
      n_mismatch = 0;
      checks     = 0;
      repeat (16) @(posedge ref_clk);
      rstn <= 1'b1;
      for (int k = 0; k < 8; k++) rd_chk(RA[k], RV[k], "reset value");
      wr(OFS_CLOCK_SELECT_CONTROL, 16'hFFFF);
      rd_chk(OFS_CLOCK_SELECT_CONTROL, 16'h01F3, "clock fields");
      wr(OFS_MODE_SELECT, 16'hFFFF);
      rd_chk(OFS_MODE_SELECT, 16'h0001, "mode field");
      wr(OFS_INTERRUPT_ENABLE, 16'hFFFF);
      rd_chk(OFS_INTERRUPT_ENABLE, 16'h0001, "irq enable field");
      wr(OFS_COUNTER_VALUE, 16'h1234);
      rd_chk(OFS_COUNTER_VALUE, 16'hFFFF, "counter read-only");
      wr(4'hE, 16'h1234);
      rd_chk(4'hE, 16'h0000, "unmapped");
      wr(OFS_RUN_CONTROL, 16'h0102);
      rd_chk(OFS_RUN_CONTROL, 16'h0000, "start without enable");
      // Initialisation in the required order, then one period per clock setting.
      wr(OFS_CLOCK_SELECT_CONTROL, 16'h0000);
      wr(OFS_RUN_CONTROL, 16'h0001);
      wr(OFS_MODE_SELECT, 16'h0000);
      wr(OFS_RELOAD_VALUE, 16'h0002);
      wr(OFS_INTERRUPT_FLAG, 16'h0001);
      wr(OFS_INTERRUPT_ENABLE, 16'h0000);
      for (int k = 0; k < 6; k++) begin
         wr(OFS_CLOCK_SELECT_CONTROL, CK[k]);
         wr(OFS_RUN_CONTROL, 16'h0103);
         wait_pulses(3);
         `CHK("underflow period", GAP[k], pulse_gap)
         wr(OFS_RUN_CONTROL, 16'h0001);
         wait_ctl(16'h0100, 16'h0000);
      end
      `CHK("irq masked", 1'b0, irq)
      wr(OFS_INTERRUPT_FLAG, 16'h0000);
      rd_chk(OFS_INTERRUPT_FLAG, 16'h0001, "flag after write 0");
      wr(OFS_INTERRUPT_ENABLE, 16'h0001);
      rd(OFS_INTERRUPT_FLAG, v);
      `CHK("irq enabled", 1'b1, irq)
      wr(OFS_INTERRUPT_FLAG, 16'h0001);
      rd_chk(OFS_INTERRUPT_FLAG, 16'h0000, "flag cleared");
      `CHK("irq after clear", 1'b0, irq)
      wr(OFS_MODE_SELECT, 16'h0001);
      wr(OFS_RELOAD_VALUE, 16'h0001);
      wr(OFS_CLOCK_SELECT_CONTROL, 16'h0000);
      n0 = pulse_count;
      wr(OFS_RUN_CONTROL, 16'h0103);
      wait_ctl(16'h0100, 16'h0000);
      repeat (100) @(posedge ref_clk);
      `CHK("one-shot pulses", n0 + 1, pulse_count)
      rd_chk(OFS_COUNTER_VALUE, 16'h0001, "one-shot reload");
      rd_chk(OFS_INTERRUPT_FLAG, 16'h0001, "one-shot flag");
      wr(OFS_MODE_SELECT, 16'h0000);
      wr(OFS_RELOAD_VALUE, 16'h0100);
      debug_halt <= 1'b1;
      wr(OFS_RUN_CONTROL, 16'h0103);
      repeat (40) @(posedge ref_clk);
      rd_chk(OFS_RUN_CONTROL, 16'h0103, "pending in halt");
      rd_chk(OFS_COUNTER_VALUE, 16'h0001, "halt freeze");
      debug_halt <= 1'b0;
      wait_ctl(16'h0002, 16'h0000);
      debug_halt <= 1'b1;
      repeat (10) @(posedge ref_clk);
      rd(OFS_COUNTER_VALUE, a);
      repeat (100) @(posedge ref_clk);
      rd_chk(OFS_COUNTER_VALUE, a, "halted counter");
      wr(OFS_CLOCK_SELECT_CONTROL, 16'h0100);
      repeat (100) @(posedge ref_clk);
      rd(OFS_COUNTER_VALUE, v);
      `CHK("debug-run counter moves", 1'b1, v !== a)
      wr(OFS_RUN_CONTROL, 16'h0000);
      repeat (10) @(posedge ref_clk);
      rd(OFS_COUNTER_VALUE, a);
      repeat (100) @(posedge ref_clk);
      rd_chk(OFS_COUNTER_VALUE, a, "gated counter");
      wr(OFS_RUN_CONTROL, 16'h0001);
      wait_ctl(16'h0100, 16'h0000);
      debug_halt <= 1'b0;
      test_done();
   end
endmodule
